// *** hw/alu_pkg.sv ***
package alu_pkg;

  // ***************************************************************
  // widths and reset values
  // ***************************************************************
  localparam int unsigned DATA_WIDTH      = 8;
  localparam logic [7:0]  WORK_RESET      = 8'h00;
  localparam logic [7:0]  WRITE_RESET     = 8'h00;
  localparam logic        FLAG_RESET      = 1'h0;
  localparam logic        WE_RESET        = 1'h0;
  localparam int unsigned NIBBLE_TOP      = 3;
  localparam int unsigned SIGN_BIT        = 7;

  // ***************************************************************
  // operation select
  // ***************************************************************
  typedef enum logic [3:0] {
    OP_SUM_CARRY_TO_WORK = 4'h0,
    OP_SUM_CARRY_TO_MEM  = 4'h1,
    OP_SUM_TO_WORK_MEM   = 4'h2,
    OP_SUM_TO_WORK_IMM   = 4'h3,
    OP_SUM_TO_MEM        = 4'h4,
    OP_AND_TO_WORK_MEM   = 4'h5,
    OP_AND_TO_WORK_IMM   = 4'h6,
    OP_AND_TO_MEM        = 4'h7
  } op_type;

endpackage : alu_pkg

// *** hw/adder_core.sv ***
`timescale 1ns/100ps
module adder_core
  import alu_pkg::*;
(
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  input  wire logic       carry_i,
  output logic      [7:0] sum_o,
  output logic            carry_o,
  output logic            half_o,
  output logic            excess_o
);

  logic [4:0] low;
  logic [4:0] high;

  always_comb begin
    low      = {1'h0, a_i[3:0]} + {1'h0, b_i[3:0]} + {4'h0, carry_i};
    high     = {1'h0, a_i[7:4]} + {1'h0, b_i[7:4]} + {4'h0, low[4]};
    sum_o    = {high[3:0], low[3:0]};
    half_o   = low[4]; // RULE_10
    carry_o  = high[4]; // RULE_10
    // signed overflow: like-signed operands give an opposite-signed sum
    excess_o = (a_i[SIGN_BIT] == b_i[SIGN_BIT]) && (sum_o[SIGN_BIT] != a_i[SIGN_BIT]); // RULE_10
  end

endmodule : adder_core

// *** hw/accumulator_add_and_logic_ops.sv ***
`timescale 1ns/100ps
// Overview of operation
// RULE_01 - add-with-carry puts memory byte plus working register plus carry into working register
// RULE_02 - add-with-carry to memory writes sum back, working register kept
// RULE_03 - plain add of memory byte into working register, no carry-in
// RULE_04 - immediate add into working register
// RULE_05 - plain add of working register into memory byte, written back
// RULE_06 - every add updates excess, null, nibble, carry and signed flags
// RULE_07 - and of memory into working register, only null flag changes
// RULE_08 - and of immediate into working register, only null flag changes
// RULE_09 - and into memory byte written back, only null flag changes
// RULE_10 - 8-bit data; zero, carry out bit 7, carry out bit 3, overflow
module accumulator_add_and_logic_ops
  import alu_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       exec_i,
  input  wire op_type     op_i,
  input  wire logic [7:0] mem_data_i,
  input  wire logic [7:0] imm_data_i,
  output logic      [7:0] working_register_o,
  output logic      [7:0] mem_wdata_o,
  output logic            mem_we_o,
  output logic            twos_complement_excess_flag_o,
  output logic            result_null_flag_o,
  output logic            nibble_wrap_flag_o,
  output logic            wrap_out_flag_o,
  output logic            signed_result_flag_o
);

  // ***************************************************************
  // state
  // ***************************************************************
  // every output is a field here, so each port leaves a flop directly
  typedef struct packed {
    logic [7:0] work;
    logic [7:0] wdata;
    logic       we;
    logic       excess;
    logic       null_f;
    logic       nibble;
    logic       wrap;
    logic       sign;
  } state_type;

  state_type cur;
  state_type next_cur;

  logic      [7:0] add_b;
  logic            add_cin;
  logic      [7:0] sum;
  logic            sum_carry;
  logic            sum_half;
  logic            sum_excess;
  wire logic [7:0] conj;
  logic            sum_null;
  logic            conj_null;
  logic            sum_sign;

  // reset image kept in one place, every field from a package constant
  localparam state_type RESET_STATE = '{
    work   : WORK_RESET,
    wdata  : WRITE_RESET,
    we     : WE_RESET,
    excess : FLAG_RESET,
    null_f : FLAG_RESET,
    nibble : FLAG_RESET,
    wrap   : FLAG_RESET,
    sign   : FLAG_RESET
  };

  // ***************************************************************
  // operation decode
  // ***************************************************************
  function automatic logic is_add(input op_type op);
    is_add = (op == OP_SUM_CARRY_TO_WORK) || (op == OP_SUM_CARRY_TO_MEM) || (op == OP_SUM_TO_WORK_MEM)
          || (op == OP_SUM_TO_WORK_IMM) || (op == OP_SUM_TO_MEM);
  endfunction : is_add

  // only the two with-carry forms see the stored carry
  function automatic logic takes_carry(input op_type op);
    takes_carry = (op == OP_SUM_CARRY_TO_WORK) || (op == OP_SUM_CARRY_TO_MEM);
  endfunction : takes_carry

  function automatic logic takes_imm(input op_type op);
    takes_imm = (op == OP_SUM_TO_WORK_IMM) || (op == OP_AND_TO_WORK_IMM);
  endfunction : takes_imm

  function automatic logic is_conj(input op_type op);
    is_conj = (op == OP_AND_TO_WORK_MEM) || (op == OP_AND_TO_WORK_IMM) || (op == OP_AND_TO_MEM);
  endfunction : is_conj

  // memory forms raise the write strobe for exactly one cycle
  function automatic logic writes_mem(input op_type op);
    writes_mem = (op == OP_SUM_CARRY_TO_MEM) || (op == OP_SUM_TO_MEM) || (op == OP_AND_TO_MEM);
  endfunction : writes_mem

  function automatic logic is_null_value(input logic [7:0] value);
    is_null_value = (value == 8'h00);
  endfunction : is_null_value

  // ***************************************************************
  // operand select
  // ***************************************************************
  always_comb begin
    add_b   = takes_imm(op_i) ? imm_data_i : mem_data_i; // RULE_04 RULE_08
    // carry-in taken from the flag as it stood before this instruction
    add_cin = takes_carry(op_i) ? cur.wrap : 1'h0; // RULE_01 RULE_03
  end

  // ***************************************************************
  // logic unit
  // ***************************************************************
  // one gate per bit; the logic forms share the adder's operand select
  for (genvar bit_idx = 0; bit_idx < DATA_WIDTH; bit_idx++) begin : g_conj
    assign conj[bit_idx] = cur.work[bit_idx] & add_b[bit_idx]; // RULE_07 RULE_08 RULE_09
  end

  // ***************************************************************
  // adder
  // ***************************************************************
  // a nibble split gives the half carry without a second adder
  adder_core u_adder (
    .a_i      (cur.work),
    .b_i      (add_b),
    .carry_i  (add_cin),
    .sum_o    (sum),
    .carry_o  (sum_carry),
    .half_o   (sum_half),
    .excess_o (sum_excess)
  );

  // ***************************************************************
  // flag unit
  // ***************************************************************
  always_comb begin
    sum_null  = is_null_value(sum); // RULE_10
    conj_null = is_null_value(conj); // RULE_10
    // true sign: an overflow flips bit 7, so bit 7 alone would mislead
    sum_sign  = sum[SIGN_BIT] ^ sum_excess; // RULE_06
  end

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    next_cur    = cur;
    // the write strobe is a one-cycle pulse, so it falls by default
    next_cur.we = 1'h0;
    // without exec every input but reset is ignored
    if (exec_i) begin
      if (is_add(op_i)) begin
        next_cur.excess = sum_excess; // RULE_06
        next_cur.null_f = sum_null; // RULE_06
        next_cur.nibble = sum_half; // RULE_06
        next_cur.wrap   = sum_carry; // RULE_06
        next_cur.sign   = sum_sign; // RULE_06
      end
      if (is_conj(op_i)) begin
        // logic forms leave carry, nibble, excess and sign alone
        next_cur.null_f = conj_null; // RULE_07 RULE_08 RULE_09
      end
      next_cur.we = writes_mem(op_i); // RULE_02 RULE_05 RULE_09
      unique case (op_i)
        OP_SUM_CARRY_TO_WORK: begin
          next_cur.work = sum; // RULE_01
        end
        OP_SUM_CARRY_TO_MEM: begin
          next_cur.wdata = sum; // RULE_02
        end
        OP_SUM_TO_WORK_MEM: begin
          next_cur.work = sum; // RULE_03
        end
        OP_SUM_TO_WORK_IMM: begin
          next_cur.work = sum; // RULE_04
        end
        OP_SUM_TO_MEM: begin
          next_cur.wdata = sum; // RULE_05
        end
        OP_AND_TO_WORK_MEM: begin
          next_cur.work = conj; // RULE_07
        end
        OP_AND_TO_WORK_IMM: begin
          next_cur.work = conj; // RULE_08
        end
        OP_AND_TO_MEM: begin
          next_cur.wdata = conj; // RULE_09
        end
        default: begin
          // unused operation codes leave all state alone except the write strobe, which falls
          next_cur.we = 1'h0;
        end
      endcase
    end
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cur <= RESET_STATE;
    end else begin
      cur <= next_cur;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  // plain wires off the state register, no logic after the flops
  always_comb begin
    working_register_o            = cur.work;
    mem_wdata_o                   = cur.wdata;
    mem_we_o                      = cur.we;
    twos_complement_excess_flag_o = cur.excess;
    result_null_flag_o            = cur.null_f;
    nibble_wrap_flag_o            = cur.nibble;
    wrap_out_flag_o               = cur.wrap;
    signed_result_flag_o          = cur.sign;
  end

endmodule : accumulator_add_and_logic_ops

// *** tb/accumulator_add_and_logic_ops_properties.sv ***
`timescale 1ns/100ps
module alu_chk
  import alu_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic       exec_i,
  input wire op_type     op_i,
  input wire logic [7:0] mem_data_i,
  input wire logic [7:0] imm_data_i,
  input wire logic [7:0] working_register_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic       mem_we_o,
  input wire logic       twos_complement_excess_flag_o,
  input wire logic       result_null_flag_o,
  input wire logic       nibble_wrap_flag_o,
  input wire logic       wrap_out_flag_o,
  input wire logic       signed_result_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] w;
  assign w = working_register_o;
  a_carry_work: assert property (exec_i && op_i == OP_SUM_CARRY_TO_WORK |=>
    w == $past(w) + $past(mem_data_i) + $past(wrap_out_flag_o)) else $error("carry add to work wrong");
  a_we_pulse: assert property (exec_i && op_i inside {OP_SUM_CARRY_TO_MEM, OP_SUM_TO_MEM, OP_AND_TO_MEM} |=>
    mem_we_o && $stable(w)) else $error("memory write missing");
  a_sum_work: assert property (exec_i && op_i == OP_SUM_TO_WORK_MEM |=>
    w == $past(w) + $past(mem_data_i)) else $error("add to work wrong");
  a_imm_sum: assert property (exec_i && op_i == OP_SUM_TO_WORK_IMM |=>
    w == $past(w) + $past(imm_data_i)) else $error("immediate add wrong");
  a_mem_sum: assert property (exec_i && op_i == OP_SUM_TO_MEM |=>
    mem_wdata_o == $past(w) + $past(mem_data_i)) else $error("add to memory wrong");
  a_and_flags: assert property (exec_i && op_i inside {OP_AND_TO_WORK_MEM, OP_AND_TO_WORK_IMM, OP_AND_TO_MEM} |=>
    $stable({wrap_out_flag_o, nibble_wrap_flag_o, twos_complement_excess_flag_o, signed_result_flag_o}))
    else $error("and changed arithmetic flags");
  a_and_null: assert property (exec_i && op_i == OP_AND_TO_WORK_MEM |=>
    result_null_flag_o == (w == 8'h00)) else $error("zero flag wrong after and");
  a_sign_flag: assert property (exec_i && op_i < OP_AND_TO_WORK_MEM |=>
    signed_result_flag_o == ((mem_we_o ? mem_wdata_o[7] : w[7]) ^ twos_complement_excess_flag_o))
    else $error("sign flag wrong");
  a_carry_mem: assert property (exec_i && op_i == OP_SUM_CARRY_TO_MEM |=>
    mem_wdata_o == $past(w) + $past(mem_data_i) + $past(wrap_out_flag_o))
    else $error("carry add to memory wrong");
  a_imm_and: assert property (exec_i && op_i == OP_AND_TO_WORK_IMM |=>
    w == ($past(w) & $past(imm_data_i)) && result_null_flag_o == (w == 8'h00)) else $error("immediate and wrong");
  a_mem_and: assert property (exec_i && op_i == OP_AND_TO_MEM |=>
    mem_wdata_o == ($past(w) & $past(mem_data_i)) && $stable(w)) else $error("and to memory wrong");
  a_add_null: assert property (exec_i && op_i < OP_AND_TO_WORK_MEM |=>
    result_null_flag_o == ((mem_we_o ? mem_wdata_o : w) == 8'h00)) else $error("zero flag wrong after add");
  a_we_drop: assert property (
    !(exec_i && op_i inside {OP_SUM_CARRY_TO_MEM, OP_SUM_TO_MEM, OP_AND_TO_MEM}) |=> !mem_we_o)
    else $error("memory write without a memory operation");
  c_carry_mem: cover property (exec_i && op_i == OP_SUM_CARRY_TO_MEM);
  c_and_mem: cover property (exec_i && op_i == OP_AND_TO_MEM);
  c_both: cover property (wrap_out_flag_o && twos_complement_excess_flag_o);
endmodule : alu_chk
bind accumulator_add_and_logic_ops alu_chk chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .exec_i(exec_i),
  .op_i(op_i), .mem_data_i(mem_data_i), .imm_data_i(imm_data_i), .working_register_o(working_register_o),
  .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .twos_complement_excess_flag_o(twos_complement_excess_flag_o),
  .result_null_flag_o(result_null_flag_o), .nibble_wrap_flag_o(nibble_wrap_flag_o),
  .wrap_out_flag_o(wrap_out_flag_o), .signed_result_flag_o(signed_result_flag_o));

// *** tb/accumulator_add_and_logic_ops_bench.sv ***
`timescale 1ns/100ps
module accumulator_add_and_logic_ops_bench;
  import alu_pkg::*;
  logic        clk_i = 1'h0, reset_n_i = 1'h0, exec_i = 1'h0, we_o, exc_o, z_o, nib_o, c_o, sgn_o;
  logic        exc = 1'h0, z = 1'h0, nib = 1'h0, c = 1'h0, sgn = 1'h0;
  op_type      op_i = OP_SUM_CARRY_TO_WORK;
  logic [7:0]  mem_data_i = 8'h00, imm_data_i = 8'h00, w_o, wd_o, w = 8'h00, wd = 8'h00, lf = 8'h50, m;
  logic [20:0] notes[$];
  int          err_count = 0, check_count = 0;
  always #50 clk_i = ~clk_i;
  accumulator_add_and_logic_ops dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .exec_i(exec_i), .op_i(op_i),
    .mem_data_i(mem_data_i), .imm_data_i(imm_data_i), .working_register_o(w_o), .mem_wdata_o(wd_o),
    .mem_we_o(we_o), .twos_complement_excess_flag_o(exc_o), .result_null_flag_o(z_o),
    .nibble_wrap_flag_o(nib_o), .wrap_out_flag_o(c_o), .signed_result_flag_o(sgn_o));
  function automatic logic [7:0] lfsr(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  task automatic check(logic [20:0] seen, logic [20:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic run(logic [3:0] op, logic [7:0] mv, logic [7:0] iv);
    logic [7:0] b, r;
    logic [8:0] s;
    logic       ci, we;
    @(negedge clk_i);
    exec_i = 1;
    op_i = op_type'(op);
    mem_data_i = mv;
    imm_data_i = iv;
    b = (op == 4'h3 || op == 4'h6) ? iv : mv;
    ci = (op < 4'h2) ? c : 1'b0;
    we = op inside {4'h1, 4'h4, 4'h7};
    // opcodes 8..15 leave every shadow value alone
    if (op < 4'h5) begin
      s = w + b + ci;
      r = s[7:0];
      nib = (w[3:0] + b[3:0] + ci) > 5'h0F;
      exc = (w[7] == b[7]) && (r[7] != w[7]);
      sgn = r[7] ^ exc;
      c = s[8];
    end else r = w & b;
    if (op < 4'h8) begin
      z = (r == 8'h00);
      if (we) wd = r;
      else w = r;
    end
    notes.push_back({w, wd, we, exc, z, nib, c, sgn});
  endtask : run
  always @(posedge clk_i) if (exec_i && reset_n_i) begin
    #1 check({w_o, wd_o, we_o, exc_o, z_o, nib_o, c_o, sgn_o}, notes.pop_front());
  end
  initial begin
    #(100 * 3000);
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (20) @(negedge clk_i);
    reset_n_i = 1'h1;
    check({w_o, wd_o, we_o, exc_o, z_o, nib_o, c_o, sgn_o}, 21'h000000);
    // boundaries first: signed overflow, carry out with zero result, then carry back in
    run(4'h3, 8'h00, 8'h7F);
    run(4'h3, 8'h00, 8'h01);
    run(4'h4, 8'h80, 8'h00);
    run(4'h0, 8'h00, 8'h00);
    run(4'h1, 8'hFF, 8'h00);
    for (int k = 0; k < 16; k++) run(k[3:0], 8'h0F, 8'hF1);
    // reset in mid-run: all state clears, so the next carry add sees no carry
    @(negedge clk_i);
    exec_i    = 1'h0;
    reset_n_i = 1'h0;
    repeat (2) @(negedge clk_i);
    check({w_o, wd_o, we_o, exc_o, z_o, nib_o, c_o, sgn_o}, 21'h000000);
    {w, wd, exc, z, nib, c, sgn} = 21'h000000;
    reset_n_i = 1'h1;
    run(4'h0, 8'hFF, 8'h00);
    for (int k = 0; k < 300; k++) begin
      lf = lfsr(lf);
      m = lf;
      lf = lfsr(lf);
      run(lf[3:0], m, lf ^ 8'h3C);
      if (lf[7]) begin
        @(negedge clk_i);
        exec_i = 0;
      end
    end
    @(negedge clk_i);
    exec_i = 0;
    repeat (3) @(negedge clk_i);
    wrap_up();
  end
endmodule : accumulator_add_and_logic_ops_bench
